// >>> acr_pkg.sv
// Constants for the converter control and result register block.
`default_nettype none
package acr_pkg;
	localparam logic [7:0] ACR_IDX_RESULT_LOW = 8'h04;
	localparam logic [7:0] ACR_IDX_RESULT_HIGH = 8'h05;
	localparam logic [7:0] ACR_IDX_CONTROL_A = 8'h06;
	localparam logic [7:0] ACR_IDX_INPUT_SELECT = 8'h07;
	localparam logic [7:0] ACR_IDX_CONTROL_B = 8'h03;
	localparam int ACR_A_ENABLE = 7;
	localparam int ACR_A_START = 6;
	localparam int ACR_A_AUTO = 5;
	localparam int ACR_A_FLAG = 4;
	localparam int ACR_A_IE = 3;
	localparam int ACR_M_REF = 6;
	localparam int ACR_B_STORE_HI = 5;
	localparam int ACR_B_LEFT = 4;
	localparam int ACR_B_STORE_LO = 3;
	localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
	localparam logic [4:0] ACR_FIRST_CLOCKS = 5'd25;
	localparam logic [4:0] ACR_NORMAL_CLOCKS = 5'd13;
	localparam logic [2:0] ACR_TRIG_FREE_RUN = 3'h0;
	localparam logic [31:0] ACR_DATA_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> acr_top.sv
// Converter control, status and result registers behind an APB slave.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module acr_top
	import acr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:1] trigger_flags,
	input wire logic global_int_enable,
	input wire logic int_vector_ack,
	input wire logic [9:0] sample_code,
	output logic irq,
	output logic converter_power,
	output logic conversion_active,
	output logic reference_select_bit,
	output logic [2:0] channel_select_field
);
	function automatic logic [6:0] div_mask(input logic [2:0] code);
		case (code)
			3'd0, 3'd1: div_mask = 7'h01;
			3'd2: div_mask = 7'h03;
			3'd3: div_mask = 7'h07;
			3'd4: div_mask = 7'h0f;
			3'd5: div_mask = 7'h1f;
			3'd6: div_mask = 7'h3f;
			default: div_mask = 7'h7f;
		endcase
	endfunction

	function automatic logic [15:0] fmt(input logic [9:0] r, input logic left);
		fmt = left ? {r, 6'h00} : {6'h00, r};
	endfunction

	function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		idx_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
	endfunction

	typedef enum logic [1:0] {ACR_IDLE, ACR_ACCESS, ACR_DONE} acr_bus_e;

	acr_bus_e bus_q, bus_d;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, irq_q;
	logic en_q, auto_q, flag_q, ie_q;
	logic [2:0] ps_q, ts_q;
	logic lar_q, store_hi_q, store_lo_q;
	logic ref_wr_q, ref_app_q;
	logic [2:0] mux_wr_q, mux_app_q;
	logic busy_q, first_q, first_conv_q, lock_q, trig_prev_q;
	logic [6:0] pre_q;
	logic [4:0] cnt_q;
	logic [9:0] result_q;

	wire hit_lo = idx_hit(paddr, ACR_IDX_RESULT_LOW);
	wire hit_hi = idx_hit(paddr, ACR_IDX_RESULT_HIGH);
	wire hit_a = idx_hit(paddr, ACR_IDX_CONTROL_A);
	wire hit_m = idx_hit(paddr, ACR_IDX_INPUT_SELECT);
	wire hit_b = idx_hit(paddr, ACR_IDX_CONTROL_B);
	wire hit_any = hit_lo | hit_hi | hit_a | hit_m | hit_b;
	wire commit = psel && penable && pready_q;
	wire wr_ok = commit && pwrite && !pslverr_q;
	wire rd_ok = commit && !pwrite && !pslverr_q;
	wire wr_a = wr_ok && hit_a;
	wire wr_m = wr_ok && hit_m;
	wire wr_b = wr_ok && hit_b;
	wire rd_lo = rd_ok && hit_lo;
	wire rd_hi = rd_ok && hit_hi;
	wire en_d = wr_a ? pwdata[ACR_A_ENABLE] : en_q;
	wire auto_d = wr_a ? pwdata[ACR_A_AUTO] : auto_q;
	wire [2:0] ts_d = wr_b ? pwdata[2:0] : ts_q;
	wire [6:0] mask = div_mask(ps_q);
	wire tick = busy_q && ((pre_q & mask) == mask);
	wire [4:0] conv_len = first_conv_q ? ACR_FIRST_CLOCKS : ACR_NORMAL_CLOCKS;
	wire done = tick && (cnt_q == conv_len - 5'd1) && en_d;
	wire trig_sel = (ts_q == ACR_TRIG_FREE_RUN) ? 1'b0 : trigger_flags[ts_q];
	wire trig_edge = trig_sel && !trig_prev_q;
	wire sw_start = wr_a && pwdata[ACR_A_START];
	wire auto_start = auto_q && trig_edge;
	wire free_restart = done && auto_q && (ts_q == ACR_TRIG_FREE_RUN);
	wire start = en_d && ((!busy_q && (sw_start || auto_start)) || free_restart);
	wire abort = busy_q && !en_d;
	wire busy_d = start || (busy_q && !done && !abort);
	wire flag_clr = (wr_a && pwdata[ACR_A_FLAG]) || int_vector_ack;
	wire flag_d = done || (flag_q && !flag_clr);
	wire [15:0] res_view = fmt(result_q, lar_q);
	wire [7:0] ctrl_a_view = {en_q, busy_q, auto_q, flag_q, ie_q, ps_q};
	wire [7:0] mux_view = {1'b0, ref_wr_q, 3'b000, mux_wr_q};
	wire [7:0] ctrl_b_view = {2'b00, store_hi_q, lar_q, store_lo_q, ts_q};
	wire [7:0] rd_byte = hit_lo ? res_view[7:0] :
		hit_hi ? res_view[15:8] :
		hit_a ? ctrl_a_view :
		hit_m ? mux_view :
		hit_b ? ctrl_b_view : ACR_RESET_BYTE;

	always_comb begin
		bus_d = bus_q;
		case (bus_q)
			ACR_IDLE: begin
				if (psel && !penable)
					bus_d = ACR_ACCESS;
			end
			ACR_ACCESS: begin
				if (psel && penable)
					bus_d = ACR_DONE;
			end
			ACR_DONE: bus_d = ACR_IDLE;
			default: bus_d = ACR_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q <= ACR_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= ACR_DATA_ZERO;
		end else begin
			bus_q <= bus_d;
			pready_q <= (bus_q == ACR_ACCESS) && psel && penable;
			pslverr_q <= (bus_q == ACR_ACCESS) && psel && penable && !hit_any;
			if ((bus_q == ACR_ACCESS) && psel && penable && !pwrite)
				prdata_q <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
			auto_q <= 1'b0;
			ie_q <= 1'b0;
			ps_q <= 3'h0;
			ts_q <= 3'h0;
			lar_q <= 1'b0;
			store_hi_q <= 1'b0;
			store_lo_q <= 1'b0;
			ref_wr_q <= 1'b0;
			mux_wr_q <= 3'h0;
		end else begin
			en_q <= en_d;
			auto_q <= auto_d;
			ts_q <= ts_d;
			if (wr_a) begin
				ie_q <= pwdata[ACR_A_IE];
				ps_q <= pwdata[2:0];
			end
			if (wr_b) begin
				store_hi_q <= pwdata[ACR_B_STORE_HI];
				lar_q <= pwdata[ACR_B_LEFT];
				store_lo_q <= pwdata[ACR_B_STORE_LO];
			end
			if (wr_m) begin
				ref_wr_q <= pwdata[ACR_M_REF];
				mux_wr_q <= pwdata[2:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			first_q <= 1'b1;
			first_conv_q <= 1'b0;
			cnt_q <= 5'h00;
			pre_q <= 7'h00;
			flag_q <= 1'b0;
			lock_q <= 1'b0;
			trig_prev_q <= 1'b0;
			result_q <= 10'h000;
			ref_app_q <= 1'b0;
			mux_app_q <= 3'h0;
		end else begin
			busy_q <= busy_d;
			flag_q <= flag_d;
			trig_prev_q <= trig_sel;
			first_q <= !en_d || (first_q && !start);
			if (start) begin
				first_conv_q <= first_q;
				cnt_q <= 5'h00;
				pre_q <= 7'h00;
			end else begin
				pre_q <= pre_q + 7'h01;
				if (tick)
					cnt_q <= cnt_q + 5'h01;
			end
			if (done && !lock_q)
				result_q <= sample_code;
			if (rd_lo)
				lock_q <= 1'b1;
			else if (rd_hi)
				lock_q <= 1'b0;
			if (!busy_q || done) begin
				ref_app_q <= ref_wr_q;
				mux_app_q <= mux_wr_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= flag_q && ie_q && global_int_enable;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign converter_power = en_q;
	assign conversion_active = busy_q;
	assign reference_select_bit = ref_app_q;
	assign channel_select_field = mux_app_q;

	property p_ref_held;
		@(posedge pclk) disable iff (!presetn)
		busy_q && !done |=> ref_app_q == $past(ref_app_q);
	endproperty
	a_ref_held: assert property (p_ref_held) else $error("reference changed mid conversion");

	property p_mux_held;
		@(posedge pclk) disable iff (!presetn)
		busy_q && !done |=> mux_app_q == $past(mux_app_q);
	endproperty
	a_mux_held: assert property (p_mux_held) else $error("channel changed mid conversion");

	sequence s_disable_write;
		wr_a && !pwdata[ACR_A_ENABLE];
	endsequence
	property p_abort;
		@(posedge pclk) disable iff (!presetn)
		s_disable_write |=> !busy_q && !converter_power;
	endproperty
	a_abort: assert property (p_abort) else $error("disable did not abort");

	property p_done_flag;
		@(posedge pclk) disable iff (!presetn)
		done |=> flag_q ##1 (irq == (ie_q && $past(global_int_enable)));
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("completion flag not set");

	property p_flag_clear;
		@(posedge pclk) disable iff (!presetn)
		flag_clr && !done |=> !flag_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		lock_q && !rd_hi |=> $stable(result_q);
	endproperty
	a_lock: assert property (p_lock) else $error("result changed while locked");

	property p_ignore_trigger;
		@(posedge pclk) disable iff (!presetn)
		busy_q && !done && en_d && trig_edge |=> busy_q && cnt_q >= $past(cnt_q);
	endproperty
	a_ignore_trigger: assert property (p_ignore_trigger) else $error("trigger restarted");

	property p_free_no_edge;
		@(posedge pclk) disable iff (!presetn)
		ts_q == ACR_TRIG_FREE_RUN |-> !trig_edge;
	endproperty
	a_free_no_edge: assert property (p_free_no_edge) else $error("free running made an edge");

	property p_length;
		@(posedge pclk) disable iff (!presetn)
		done |-> cnt_q == (first_conv_q ? 5'd24 : 5'd12);
	endproperty
	a_length: assert property (p_length) else $error("wrong conversion length");

	property p_free_restart;
		@(posedge pclk) disable iff (!presetn)
		done && auto_q && ts_q == ACR_TRIG_FREE_RUN && en_d |=> busy_q && cnt_q == 5'd0;
	endproperty
	a_free_restart: assert property (p_free_restart) else $error("no free-run restart");

	sequence s_read_at(logic sel);
		commit && !pwrite && sel;
	endsequence

	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

	property p_read_upper_zero;
		@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

	property p_mux_reserved;
		@(posedge pclk) disable iff (!presetn)
		s_read_at(hit_m) |-> prdata[7] == 1'b0 && prdata[5:3] == 3'b000;
	endproperty
	a_mux_reserved: assert property (p_mux_reserved) else $error("reserved bits set");

	property p_start_readback;
		@(posedge pclk) disable iff (!presetn)
		s_read_at(hit_a) |-> prdata[ACR_A_START] == $past(busy_q);
	endproperty
	a_start_readback: assert property (p_start_readback) else $error("start bit readback");

	property p_start_zero;
		@(posedge pclk) disable iff (!presetn)
		wr_a && !pwdata[ACR_A_START] && !busy_q && !auto_start |=> !busy_q;
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("zero start began work");

	property p_off_idle;
		@(posedge pclk) disable iff (!presetn)
		!en_d |=> !busy_q;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("busy while disabled");

	property p_sw_start;
		@(posedge pclk) disable iff (!presetn)
		wr_a && pwdata[ACR_A_START] && pwdata[ACR_A_ENABLE] && !busy_q |=> busy_q && cnt_q == 5'd0;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("start write ignored");

	property p_first_conv;
		@(posedge pclk) disable iff (!presetn)
		wr_a && pwdata[ACR_A_START] && pwdata[ACR_A_ENABLE] && !en_q |=> first_conv_q;
	endproperty
	a_first_conv: assert property (p_first_conv) else $error("first conversion too short");

	property p_auto_start;
		@(posedge pclk) disable iff (!presetn)
		auto_q && en_d && trig_edge && !busy_q |=> busy_q;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("trigger edge ignored");

	property p_no_auto;
		@(posedge pclk) disable iff (!presetn)
		!auto_q && !busy_q && !sw_start |=> !busy_q;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("start without request");

	property p_irq_raise;
		@(posedge pclk) disable iff (!presetn)
		flag_q && ie_q && global_int_enable |=> irq;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

	property p_flag_keep;
		@(posedge pclk) disable iff (!presetn)
		flag_q && !flag_clr |=> flag_q;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag lost");

	property p_unlock;
		@(posedge pclk) disable iff (!presetn)
		rd_hi |=> !lock_q;
	endproperty
	a_unlock: assert property (p_unlock) else $error("result stayed locked");

	property p_capture;
		@(posedge pclk) disable iff (!presetn)
		done && !lock_q |=> result_q == $past(sample_code);
	endproperty
	a_capture: assert property (p_capture) else $error("result not captured");
endmodule
`default_nettype wire

// >>> acr_top_tb.sv
// Self-checking testbench for the converter control and result registers.
`timescale 1ns/1ps
`default_nettype none
module acr_top_tb
	import acr_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
	logic pready, pslverr, irq, converter_power, conversion_active, reference_select_bit;
	logic [2:0] channel_select_field;
	logic [7:1] trigger_flags = 7'h00;
	logic global_int_enable = 0, int_vector_ack = 0, err_q;
	logic [9:0] sample_code = 10'h000;
	int n_fail = 0, tests_run = 0, n;
	acr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger_flags(trigger_flags), .global_int_enable(global_int_enable),
		.int_vector_ack(int_vector_ack), .sample_code(sample_code), .irq(irq),
		.converter_power(converter_power), .conversion_active(conversion_active),
		.reference_select_bit(reference_select_bit), .channel_select_field(channel_select_field));
	always #2 pclk = ~pclk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			n_fail++;
		rd_q = prdata;
		err_q = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_done();
		n = 0;
		@(posedge pclk);
		while (conversion_active !== 1'b0 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
	endtask
	task automatic run(input logic [7:0] ctl, input int e);
		apb(ACR_IDX_CONTROL_A, 1, ctl);
		wait_done();
		chk(n > e - 5 && n < e + 3, 1);
		apb(ACR_IDX_CONTROL_A, 0, 0);
		chk(rd_q[7:4], ctl[7] ? 4'b1001 : 4'b0001);
	endtask
	task automatic t_reset();
		apb(ACR_IDX_CONTROL_A, 0, 0);
		chk(rd_q, 0);
		apb(ACR_IDX_RESULT_HIGH, 0, 0);
		chk(rd_q, 0);
		apb(8'h00, 0, 0);
		chk(rd_q, 0);
		chk(err_q, 1);
	endtask
	task automatic t_mux();
		apb(ACR_IDX_INPUT_SELECT, 1, 8'hFF);
		apb(ACR_IDX_INPUT_SELECT, 0, 0);
		chk(rd_q, 32'h0000_0047);
		repeat (2) @(posedge pclk);
		chk({reference_select_bit, channel_select_field}, 4'hF);
		apb(ACR_IDX_INPUT_SELECT, 1, 8'h02);
		repeat (2) @(posedge pclk);
		chk({reference_select_bit, channel_select_field}, 4'h2);
	endtask
	task automatic t_hold();
		apb(ACR_IDX_CONTROL_A, 1, 8'hC3);
		apb(ACR_IDX_INPUT_SELECT, 1, 8'h45);
		repeat (2) @(posedge pclk);
		chk({reference_select_bit, channel_select_field}, 4'h2);
		wait_done();
		chk({reference_select_bit, channel_select_field}, 4'hD);
	endtask
	task automatic t_result();
		apb(ACR_IDX_RESULT_LOW, 0, 0);
		chk(rd_q, 32'h0000_00A5);
		apb(ACR_IDX_RESULT_HIGH, 0, 0);
		chk(rd_q, 32'h0000_0002);
		apb(ACR_IDX_CONTROL_B, 1, 8'h38);
		apb(ACR_IDX_CONTROL_B, 0, 0);
		chk(rd_q, 32'h0000_0038);
		apb(ACR_IDX_RESULT_HIGH, 0, 0);
		chk(rd_q, 32'h0000_00A9);
		apb(ACR_IDX_RESULT_LOW, 0, 0);
		chk(rd_q, 32'h0000_0040);
	endtask
	task automatic t_flag();
		global_int_enable <= 1;
		apb(ACR_IDX_CONTROL_A, 1, 8'h8B);
		repeat (3) @(posedge pclk);
		chk({irq, converter_power}, 2'b11);
		apb(ACR_IDX_CONTROL_A, 1, 8'h9B);
		repeat (3) @(posedge pclk);
		chk(irq, 0);
		apb(ACR_IDX_CONTROL_A, 1, 8'hC8);
		wait_done();
		@(posedge pclk);
		int_vector_ack <= 1;
		@(posedge pclk);
		int_vector_ack <= 0;
		apb(ACR_IDX_CONTROL_A, 0, 0);
		chk(rd_q[4], 0);
	endtask
	task automatic t_lock();
		apb(ACR_IDX_CONTROL_B, 1, 8'h00);
		sample_code <= 10'h155;
		apb(ACR_IDX_RESULT_LOW, 0, 0);
		apb(ACR_IDX_CONTROL_A, 1, 8'hC0);
		wait_done();
		apb(ACR_IDX_RESULT_HIGH, 0, 0);
		chk(rd_q, 32'h0000_0002);
	endtask
	task automatic t_auto();
		apb(ACR_IDX_CONTROL_B, 1, 8'h01);
		apb(ACR_IDX_CONTROL_A, 1, 8'hB0);
		trigger_flags <= 7'h01;
		repeat (3) @(posedge pclk);
		chk(conversion_active, 1);
		apb(ACR_IDX_CONTROL_A, 1, 8'h00);
		repeat (2) @(posedge pclk);
		chk({conversion_active, converter_power}, 2'b00);
	endtask
	task automatic t_trigger();
		trigger_flags <= 7'h04;
		apb(ACR_IDX_CONTROL_B, 1, 8'h01);
		apb(ACR_IDX_CONTROL_A, 1, 8'hB0);
		repeat (2) @(posedge pclk);
		chk(conversion_active, 0);
		apb(ACR_IDX_CONTROL_B, 1, 8'h03);
		repeat (2) @(posedge pclk);
		chk(conversion_active, 1);
		wait_done();
		apb(ACR_IDX_CONTROL_B, 1, 8'h00);
		repeat (3) @(posedge pclk);
		chk(conversion_active, 0);
		apb(ACR_IDX_CONTROL_A, 1, 8'hE0);
		repeat (40) @(posedge pclk);
		apb(ACR_IDX_CONTROL_A, 0, 0);
		chk(rd_q[6:4], 3'b111);
		apb(ACR_IDX_CONTROL_A, 1, 8'h00);
		repeat (2) @(posedge pclk);
		chk(conversion_active, 0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_mux();
		sample_code <= 10'h2A5;
		run(8'hC0, 50);
		run(8'hD3, 104);
		t_hold();
		t_result();
		t_flag();
		t_lock();
		t_auto();
		t_trigger();
		summarize();
	end
	initial begin
		#100000;
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
